// ### src/emb_pkg.sv
package emb_pkg;
	// register indices; byte address is four times the index
	localparam logic [13:0] EMB_CLOCK_AND_STRETCH_CONTROL_IDX = 14'h008E;
	localparam logic [13:0] EMB_CFG_IDX = 14'h008F;
	// reset values: stretch of one, divide-by-one
	localparam logic [7:0] EMB_CLOCK_AND_STRETCH_CONTROL_RST = 8'h01;
	localparam logic [7:0] EMB_CFG_RST = 8'h02;
	// field positions in the configuration register
	localparam int EMB_CD_LSB = 0;
	localparam int EMB_MULT_BIT = 2;
	localparam int EMB_ALE_INT_BIT = 3;
	localparam int EMB_PAGE_EN_BIT = 4;
	localparam int EMB_PSEL_LSB = 5;
	localparam int EMB_BUSY_BIT = 7;
	// clock divide codes
	localparam logic [1:0] EMB_CD_DIV1 = 2'h2;
	localparam logic [1:0] EMB_CD_SLOW = 2'h3;
	// system clocks per slow tick (slowest mode is 1024x divide-by-one)
	localparam int EMB_SLOW_DIV = 1024;
	// clocks per basic external cycle and per stretch machine cycle
	localparam logic [5:0] EMB_EXT_CLKS = 6'h04;
	localparam logic [5:0] EMB_STRETCH_CLKS = 6'h04;
	// page select codes
	localparam logic [1:0] EMB_PSEL_ONE = 2'h0;
	localparam logic [1:0] EMB_PSEL_FOUR = 2'h2;
	localparam logic [1:0] EMB_PSEL_ALT = 2'h3;

	typedef enum logic {EMB_IDLE, EMB_RUN} emb_phase_t;
	typedef enum logic [1:0] {EMB_FETCH, EMB_READ, EMB_WRITE} emb_kind_t;

	// one memory request from the core
	typedef struct packed {
		emb_kind_t kind;
		logic internal;
		logic [15:0] addr;
		logic [7:0] wdata;
	} emb_req_t;

	// external bus pins
	typedef struct packed {
		logic ale;
		logic program_fetch_strobe_n;
		logic rd_n;
		logic wr_n;
		logic [7:0] addr_hi;
		logic [7:0] ad;
		logic ad_oe;
	} emb_pins_t;

	// whole state of the sequencer
	typedef struct packed {
		emb_phase_t phase;
		logic [5:0] cnt;
		logic [5:0] total;
		logic [5:0] ale_end;
		logic [5:0] st_start;
		logic [5:0] st_end;
		emb_kind_t kind;
		logic internal;
		logic [15:0] addr;
		logic [7:0] wdata;
		logic [7:0] page_hi;
		logic page_valid;
		logic [7:0] clock_and_stretch_control;
		logic [7:0] cfg;
		logic [9:0] div_cnt;
		logic tick;
		logic rdy;
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [1:0] strb_d;
		logic [1:0] fin_d;
		logic [7:0] rdata;
		logic done;
		logic ack;
		logic [7:0] rd_byte;
		emb_pins_t pins;
	} emb_state_t;
endpackage

// ### src/emb_stretch_ctrl.sv
// What this block does
// - nonpage external cycle four clocks, internal one
// - internal fetch keeps ale off unless enabled
// - external fetch pulses ale except on a page hit
// - fetch strobe only on external fetches
// - stretch from low three control bits
// - stretch machine cycle is four clocks
// - codes give 0,1,2,3,7,8,9,10 stretches
// - zero stretch adds no extra timing
// - codes 1-3 add that many stretches
// - first stretch adds one setup, one hold
// - long stretches widen ale, setup, hold, strobe
// - strobe widths scale with clock divider
// - stretch of one after reset
// - divide code 10 means divide-by-one
// - page hit and miss lengths by select
// - alternate page mode data takes four clocks at stretch code zero
`timescale 1ns/1ps
`default_nettype none
module emb_stretch_ctrl
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [15:0] wb_adr_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic [3:0] wb_sel_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic req_valid_in,
	input wire emb_pkg::emb_req_t req_in,
	output logic req_ready_out,
	output logic done_out,
	output logic [7:0] rdata_out,
	input wire logic [7:0] ad_in,
	output emb_pkg::emb_pins_t bus_out
);
	emb_pkg::emb_state_t s_reg; // registered state
	emb_pkg::emb_state_t s_next; // next state
	logic acc; // request taken this cycle
	logic run; // cycle in progress
	logic fast; // tick every clock
	logic [5:0] sc; // decoded stretch count
	logic hit; // page hit on current request
	logic [1:0] psel; // page select
	logic [5:0] base; // page cycle base length
	logic strobe; // strobe window of next state

	// stretch code to stretch machine cycles
	function automatic logic [5:0] emb_decode(input logic [2:0] code);
		emb_decode = code[2] ? {3'h0, code} + 6'h03 : {3'h0, code};
	endfunction

	assign acc = s_reg.rdy && req_valid_in;
	assign run = s_reg.phase == emb_pkg::EMB_RUN;
	assign fast = s_reg.cfg[emb_pkg::EMB_CD_LSB +: 2] != emb_pkg::EMB_CD_SLOW;
	assign sc = emb_decode(s_reg.clock_and_stretch_control[2:0]);
	assign psel = s_reg.cfg[emb_pkg::EMB_PSEL_LSB +: 2];
	assign hit = s_reg.page_valid && s_reg.page_hi == req_in.addr[15:8];
	assign base = psel == emb_pkg::EMB_PSEL_ONE ? 6'h01 : psel == emb_pkg::EMB_PSEL_FOUR ? 6'h04 : 6'h02;

	// outputs straight from the state register
	assign wb_dat_out = {24'h000000, s_reg.rd_byte};
	assign wb_ack_out = s_reg.ack;
	assign req_ready_out = s_reg.rdy;
	assign done_out = s_reg.done;
	assign rdata_out = s_reg.rdata;
	assign bus_out = s_reg.pins;

	// next-state logic for bus slave, divider and sequencer
	always_comb
	begin
		s_next = s_reg;
		strobe = 1'b0;
		s_next.done = s_reg.fin_d[1];
		// pin synchroniser
		s_next.sync1 = ad_in;
		s_next.sync2 = s_reg.sync1;
		// system clock enable; divide-by-one ticks every clock
		if (!fast)
		begin
			s_next.tick = s_reg.div_cnt == 10'(emb_pkg::EMB_SLOW_DIV - 1);
			s_next.div_cnt = s_next.tick ? 10'h000 : s_reg.div_cnt + 10'h001;
		end
		else
		begin
			// code 10 and the multiplier codes run at sys clock
			s_next.tick = 1'b1;
			s_next.div_cnt = 10'h000;
		end
		// wishbone slave: one wait state, ack for one cycle
		s_next.ack = wb_cyc_in && wb_stb_in && !s_reg.ack;
		if (s_next.ack)
		begin
			if (wb_adr_in[15:2] == emb_pkg::EMB_CLOCK_AND_STRETCH_CONTROL_IDX)
			begin
				s_next.rd_byte = s_reg.clock_and_stretch_control;
				// new stretch applies to later accesses
				if (wb_we_in && wb_sel_in[0])
					s_next.clock_and_stretch_control = wb_dat_in[7:0];
			end
			else if (wb_adr_in[15:2] == emb_pkg::EMB_CFG_IDX)
			begin
				s_next.rd_byte = {run, s_reg.cfg[6:0]};
				if (wb_we_in && wb_sel_in[0])
					s_next.cfg = {1'b0, wb_dat_in[6:0]};
			end
			else
				s_next.rd_byte = 8'h00; // unmapped reads zero
		end
		// sequencer
		case (s_reg.phase)
			emb_pkg::EMB_IDLE:
			begin
				if (acc)
				begin
					s_next.phase = emb_pkg::EMB_RUN;
					s_next.cnt = 6'h00;
					s_next.kind = req_in.kind;
					s_next.internal = req_in.internal;
					s_next.addr = req_in.addr;
					s_next.wdata = req_in.wdata;
					if (req_in.internal)
					begin
						// internal: one clock, no strobes
						s_next.total = 6'h01;
						s_next.ale_end = (req_in.kind == emb_pkg::EMB_FETCH
							&& s_reg.cfg[emb_pkg::EMB_ALE_INT_BIT]) ? 6'h01 : 6'h00;
						s_next.st_start = 6'h00;
						s_next.st_end = 6'h00;
					end
					else if (req_in.kind == emb_pkg::EMB_FETCH)
					begin
						if (s_reg.cfg[emb_pkg::EMB_PAGE_EN_BIT])
						begin
							// page fetch: miss spends half on ale
							s_next.total = hit ? base : 6'(base << 1);
							s_next.ale_end = hit ? 6'h00 : base;
						end
						else
						begin
							s_next.total = emb_pkg::EMB_EXT_CLKS;
							s_next.ale_end = 6'h01;
						end
						s_next.st_start = s_next.ale_end;
						s_next.st_end = s_next.total;
					end
					else
					begin
						// data: base cycle plus stretch machine cycles
						s_next.total = emb_pkg::EMB_EXT_CLKS
							+ 6'(sc * emb_pkg::EMB_STRETCH_CLKS);
						s_next.ale_end = sc > 6'h03 ? 6'h05 : 6'h01;
						if (sc == 6'h00)
						begin
							s_next.st_start = 6'h01;
							s_next.st_end = 6'h03;
						end
						else if (sc < 6'h04)
						begin
							// one clock setup and hold for the first step
							s_next.st_start = 6'h02;
							s_next.st_end = 6'h02 + 6'(sc * emb_pkg::EMB_STRETCH_CLKS);
						end
						else
						begin
							// ale, setup, hold and strobe each widened
							s_next.st_start = 6'h06;
							s_next.st_end = 6'h06 + 6'((sc - 6'h03) * emb_pkg::EMB_STRETCH_CLKS);
						end
					end
				end
			end
			emb_pkg::EMB_RUN:
			begin
				if (s_reg.tick)
				begin
					if (s_reg.cnt == s_reg.total - 6'h01)
					begin
						s_next.phase = emb_pkg::EMB_IDLE;
						if (!s_reg.internal)
						begin
							s_next.page_hi = s_reg.addr[15:8];
							// one-clock page mode forces a miss after data
							s_next.page_valid = !(s_reg.kind != emb_pkg::EMB_FETCH
								&& psel == emb_pkg::EMB_PSEL_ONE);
						end
					end
					else
						s_next.cnt = s_reg.cnt + 6'h01;
				end
			end
			default:
				s_next.phase = emb_pkg::EMB_IDLE;
		endcase
		// done pulse two clocks after the end, once data is caught
		s_next.fin_d = {s_reg.fin_d[0], run && s_next.phase == emb_pkg::EMB_IDLE};
		s_next.rdy = s_next.phase == emb_pkg::EMB_IDLE && s_next.tick;
		// pins from the next count
		strobe = s_next.phase == emb_pkg::EMB_RUN && s_next.cnt >= s_next.st_start
			&& s_next.cnt < s_next.st_end;
		s_next.pins.ale = s_next.phase == emb_pkg::EMB_RUN && s_next.cnt < s_next.ale_end;
		s_next.pins.program_fetch_strobe_n = !(strobe && !s_next.internal
			&& s_next.kind == emb_pkg::EMB_FETCH);
		s_next.pins.rd_n = !(strobe && !s_next.internal && s_next.kind == emb_pkg::EMB_READ);
		s_next.pins.wr_n = !(strobe && !s_next.internal && s_next.kind == emb_pkg::EMB_WRITE);
		s_next.pins.addr_hi = s_next.addr[15:8];
		s_next.pins.ad = s_next.pins.ale ? s_next.addr[7:0] : s_next.wdata;
		s_next.pins.ad_oe = s_next.phase == emb_pkg::EMB_RUN && !s_next.internal
			&& (s_next.pins.ale || (s_next.kind == emb_pkg::EMB_WRITE
			&& s_next.cnt >= s_next.ale_end));
		// capture read data as it leaves the synchroniser
		s_next.strb_d = {s_reg.strb_d[0], !s_reg.pins.program_fetch_strobe_n || !s_reg.pins.rd_n};
		if (s_reg.strb_d[1])
			s_next.rdata = s_reg.sync2;
		// synchronous reset
		if (rst_in)
		begin
			s_next = '0;
			s_next.clock_and_stretch_control = emb_pkg::EMB_CLOCK_AND_STRETCH_CONTROL_RST;
			s_next.cfg = emb_pkg::EMB_CFG_RST;
			s_next.pins.program_fetch_strobe_n = 1'b1;
			s_next.pins.rd_n = 1'b1;
			s_next.pins.wr_n = 1'b1;
		end
	end

	// state register
	always_ff @(posedge sys_clk_in)
	begin
		s_reg <= s_next;
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	// helper: request of each kind taken at sys rate in nonpage mode
	logic np_acc;
	assign np_acc = acc && fast && !s_reg.cfg[emb_pkg::EMB_PAGE_EN_BIT];

	a_ext_fetch_len: assert property (np_acc && !req_in.internal && req_in.kind == emb_pkg::EMB_FETCH
		|=> run [*4] ##1 !run) else $error("external fetch not four clocks");
	a_int_len: assert property (acc && fast && req_in.internal |=> run ##1 !run)
		else $error("internal cycle not one clock");
	a_ale_internal: assert property (s_reg.pins.ale && s_reg.internal
		|-> s_reg.cfg[emb_pkg::EMB_ALE_INT_BIT]) else $error("ale on internal fetch");
	a_ale_ext_fetch: assert property (np_acc && !req_in.internal && req_in.kind == emb_pkg::EMB_FETCH
		|=> s_reg.pins.ale ##1 !s_reg.pins.program_fetch_strobe_n) else $error("no ale on fetch");
	a_program_fetch_strobe_n_only_fetch: assert property (!s_reg.pins.program_fetch_strobe_n
		|-> !s_reg.internal && s_reg.kind == emb_pkg::EMB_FETCH) else $error("bad fetch strobe");
	a_clock_and_stretch_control_write: assert property ($rose(s_reg.ack) && $past(wb_we_in && wb_sel_in[0]
		&& wb_adr_in[15:2] == emb_pkg::EMB_CLOCK_AND_STRETCH_CONTROL_IDX) |-> s_reg.clock_and_stretch_control == $past(wb_dat_in[7:0]))
		else $error("control write lost");
	a_data_total: assert property (np_acc && !req_in.internal && req_in.kind != emb_pkg::EMB_FETCH
		|=> s_reg.total == 6'h04 + 6'($past(sc) * 6'h04)) else $error("data length wrong");
	a_code_four: assert property (acc && s_reg.clock_and_stretch_control[2:0] == 3'h4 |-> sc == 6'h07)
		else $error("stretch decode wrong");
	a_zero_stretch: assert property (np_acc && s_reg.clock_and_stretch_control[2:0] == 3'h0 && !req_in.internal
		&& req_in.kind == emb_pkg::EMB_READ |=> s_reg.pins.rd_n ##1 !s_reg.pins.rd_n [*2]
		##1 s_reg.pins.rd_n ##1 !run) else $error("zero stretch timing");
	a_first_stretch: assert property (np_acc && s_reg.clock_and_stretch_control[2:0] == 3'h1 && !req_in.internal
		&& req_in.kind == emb_pkg::EMB_WRITE |=> s_reg.pins.wr_n [*2] ##1 !s_reg.pins.wr_n [*4]
		##1 s_reg.pins.wr_n [*2] ##1 !run) else $error("first stretch timing");
	a_long_ale: assert property (np_acc && s_reg.clock_and_stretch_control[2] && !req_in.internal
		&& req_in.kind == emb_pkg::EMB_READ |=> s_reg.pins.ale [*5] ##1 !s_reg.pins.ale)
		else $error("ale not widened");
	a_slow_tick: assert property (!fast && s_reg.tick |=> !s_reg.tick [*8])
		else $error("slow tick too frequent");
	// checked at the first edge after release, while the reset values still stand
	a_reset_stretch: assert property ($fell(rst_in) |-> s_reg.clock_and_stretch_control == emb_pkg::EMB_CLOCK_AND_STRETCH_CONTROL_RST)
		else $error("reset stretch not one");
	// the two-clock antecedent keeps the release edge, whose tick is still cleared, out of the check
	a_div_one: assert property ((!rst_in && s_reg.cfg[emb_pkg::EMB_CD_LSB +: 2] == emb_pkg::EMB_CD_DIV1) [*2]
		|-> s_reg.tick) else $error("divide-by-one not every clock");
	a_page_miss: assert property (acc && fast && psel == emb_pkg::EMB_PSEL_FOUR
		&& s_reg.cfg[emb_pkg::EMB_PAGE_EN_BIT] && !hit && !req_in.internal
		&& req_in.kind == emb_pkg::EMB_FETCH |=> run [*8] ##1 !run) else $error("page miss length");
	a_alt_data: assert property (acc && fast && psel == emb_pkg::EMB_PSEL_ALT && s_reg.clock_and_stretch_control[2:0] == 3'h0
		&& !req_in.internal && req_in.kind != emb_pkg::EMB_FETCH |=> run [*4] ##1 !run)
		else $error("alt page data length");

	c_ext_fetch: cover property (np_acc && req_in.kind == emb_pkg::EMB_FETCH && !req_in.internal);
	c_long_read: cover property (np_acc && s_reg.clock_and_stretch_control[2] && req_in.kind == emb_pkg::EMB_READ);
	c_page_hit: cover property (acc && s_reg.cfg[emb_pkg::EMB_PAGE_EN_BIT] && hit);
	c_slow_write: cover property (acc && !fast && req_in.kind == emb_pkg::EMB_WRITE);
endmodule
`default_nettype wire

// ### test/emb_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// external memory with address latch on the far side of the bus
module emb_mem_model
(
	input wire logic sys_clk_in,
	input wire emb_pkg::emb_pins_t bus_in,
	output logic [7:0] ad_out
);
	logic [7:0] mem [256]; // contents, preset to a known pattern
	logic [7:0] lo_reg; // latched low address byte
	logic [7:0] last_reg = 8'h00; // last value seen on the wire while read
	logic rd_act; // fetch or read strobe low
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h5A;
	end
	assign rd_act = !bus_in.program_fetch_strobe_n || !bus_in.rd_n;
	// latch address on ale, store write data while the write strobe is low
	always @(posedge sys_clk_in)
	begin
		if (bus_in.ale)
			lo_reg <= bus_in.ad;
		if (!bus_in.wr_n && bus_in.ad_oe)
			mem[lo_reg] <= bus_in.ad;
		if (rd_act)
			last_reg <= ad_out;
	end
	// wire level: device drive wins, then memory answer, else a changing value
	always_comb
	begin
		if (bus_in.ad_oe)
			ad_out = bus_in.ad;
		else if (rd_act)
			ad_out = mem[lo_reg];
		else
			ad_out = ~last_reg;
	end
endmodule
`default_nettype wire

// ### test/external_memory_bus_stretch_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module external_memory_bus_stretch_tb_top;
	localparam logic [15:0] CK = 16'h0238; // stretch control byte address
	localparam logic [15:0] CF = 16'h023C; // configuration byte address
	localparam logic [15:0] NA = 16'hFFFF; // field not compared
	logic sys_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [15:0] adr = 16'h0000;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic ack, ready, done;
	logic valid = 1'b0;
	emb_pkg::emb_req_t req = '0;
	logic [7:0] rdata, ad_wire;
	emb_pkg::emb_pins_t pins;
	logic [15:0] t, n_ale, n_stb, st_at, dn_at; // timing of the last access
	int n_fail = 0;
	int check_count = 0;
	// free running system clock
	initial
	begin
		forever #20 sys_clk_in = ~sys_clk_in;
	end
	emb_stretch_ctrl dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
		.wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wdat), .wb_sel_in(4'h1), .wb_dat_out(rdat), .wb_ack_out(ack),
		.req_valid_in(valid), .req_in(req), .req_ready_out(ready), .done_out(done), .rdata_out(rdata),
		.ad_in(ad_wire), .bus_out(pins));
	emb_mem_model mem (.sys_clk_in(sys_clk_in), .bus_in(pins), .ad_out(ad_wire));
	// cycle labels count from the edge that takes a request
	always @(posedge sys_clk_in)
	begin
		if (valid && ready)
		begin
			t <= 16'h0000;
			n_ale <= 16'h0000;
			n_stb <= 16'h0000;
			st_at <= NA;
			dn_at <= NA;
		end
		else
		begin
			t <= t + 16'h0001;
			n_ale <= n_ale + 16'(pins.ale);
			n_stb <= n_stb + 16'(!pins.rd_n || !pins.wr_n || !pins.program_fetch_strobe_n);
			if (st_at == NA && (!pins.rd_n || !pins.wr_n || !pins.program_fetch_strobe_n))
				st_at <= t;
			if (done === 1'b1)
				dn_at <= t;
		end
	end
	task automatic chk_reg(input string what, input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_cnt(input string what, input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// classic single wishbone cycle, held until ack
	task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
		int k;
		@(posedge sys_clk_in);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h00_0000, d};
		k = 0;
		do @(posedge sys_clk_in); while (ack !== 1'b1 && ++k < 100);
		if (ack !== 1'b1)
		begin
			n_fail++;
			$display("[FAIL] %0t wishbone ack timeout", $time);
		end
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// one core request, held until taken, then wait for completion
	task automatic access(input emb_pkg::emb_kind_t kd, input logic il, input logic [15:0] a, input logic [7:0] d);
		int k;
		@(posedge sys_clk_in);
		valid <= 1'b1;
		req <= '{kd, il, a, d};
		k = 0;
		// slow divide offers ready once per 1024 clocks
		do @(posedge sys_clk_in); while (ready !== 1'b1 && ++k < 2100);
		valid <= 1'b0;
		if (ready !== 1'b1)
		begin
			n_fail++;
			$display("[FAIL] %0t request not taken", $time);
		end
		k = 0;
		do @(posedge sys_clk_in); while (done !== 1'b1 && ++k < 10000);
		if (done !== 1'b1)
		begin
			n_fail++;
			$display("[FAIL] %0t access never done", $time);
		end
		@(posedge sys_clk_in);
	endtask
	// compare ale clocks, strobe clocks, strobe start and done cycle
	task automatic expect_t(input logic [15:0] ea, input logic [15:0] es, input logic [15:0] est, input logic [15:0] ed);
		if (ea != NA)
			chk_cnt("ale clocks", n_ale, ea);
		if (es != NA)
			chk_cnt("strobe clocks", n_stb, es);
		if (est != NA)
			chk_cnt("strobe start", st_at, est);
		if (ed != NA)
			chk_cnt("done cycle", dn_at, ed);
	endtask
	task automatic t_regs;
		logic [7:0] q;
		wb(1'b0, CK, 8'h00, q);
		chk_reg("stretch reset", q, 8'h01);
		wb(1'b0, CF, 8'h00, q);
		chk_reg("divide reset", q, 8'h02);
		wb(1'b0, 16'h0100, 8'h00, q);
		chk_reg("unmapped read", q, 8'h00);
		wb(1'b1, CK, 8'h06, q);
		wb(1'b0, CK, 8'h00, q);
		chk_reg("stretch rw", q, 8'h06);
		$display("test regs done");
	endtask
	task automatic t_fetch;
		logic [7:0] q;
		wb(1'b1, CK, 8'h01, q);
		access(emb_pkg::EMB_FETCH, 1'b0, 16'h0123, 8'h00);
		expect_t(16'd1, 16'd3, 16'd1, 16'd6);
		chk_reg("fetch data", rdata, 8'h23 ^ 8'h5A);
		chk_reg("address high", pins.addr_hi, 8'h01);
		access(emb_pkg::EMB_FETCH, 1'b1, 16'h0010, 8'h00);
		expect_t(16'd0, 16'd0, NA, 16'd3);
		wb(1'b1, CF, 8'h0A, q);
		access(emb_pkg::EMB_FETCH, 1'b1, 16'h0011, 8'h00);
		chk_cnt("internal ale", 16'(n_ale != 16'h0000), 16'd1);
		access(emb_pkg::EMB_FETCH, 1'b0, 16'h0456, 8'h00);
		expect_t(16'd1, 16'd3, 16'd1, 16'd6);
		wb(1'b1, CF, 8'h02, q);
		$display("test fetch done");
	endtask
	task automatic t_stretch;
		logic [7:0] q;
		int s;
		for (int c = 0; c < 8; c++)
		begin
			s = (c < 4) ? c : c + 3;
			wb(1'b1, CK, 8'(c), q);
			access(emb_pkg::EMB_READ, 1'b0, 16'h0040 + 16'(c), 8'h00);
			expect_t(c < 4 ? 16'd1 : 16'd5, c == 0 ? 16'd2 : 16'(4 * c), c < 2 ? 16'(c + 1) : c < 4 ? NA : 16'd6,
				16'(6 + 4 * s));
			chk_reg("read data", rdata, (8'h40 + 8'(c)) ^ 8'h5A);
		end
		wb(1'b1, CK, 8'h01, q);
		access(emb_pkg::EMB_WRITE, 1'b0, 16'h0077, 8'hC3);
		expect_t(16'd1, 16'd4, 16'd2, 16'd10);
		access(emb_pkg::EMB_READ, 1'b0, 16'h0077, 8'h00);
		chk_reg("read back", rdata, 8'hC3);
		$display("test stretch done");
	endtask
	task automatic t_page;
		logic [7:0] q;
		wb(1'b1, CK, 8'h00, q);
		for (int p = 0; p < 3; p++)
		begin
			wb(1'b1, CF, 8'h12 + 8'(p << 5), q);
			access(emb_pkg::EMB_FETCH, 1'b0, {8'h20 + 8'(p), 8'h00}, 8'h00);
			expect_t(NA, NA, NA, 16'((2 << p) + 2));
			access(emb_pkg::EMB_FETCH, 1'b0, {8'h20 + 8'(p), 8'h01}, 8'h00);
			expect_t(NA, NA, NA, 16'((1 << p) + 2));
		end
		wb(1'b1, CF, 8'h72, q);
		access(emb_pkg::EMB_READ, 1'b0, 16'h2200, 8'h00);
		expect_t(NA, NA, NA, 16'd6);
		wb(1'b1, CF, 8'h02, q);
		$display("test page done");
	endtask
	task automatic t_slow;
		logic [7:0] q;
		wb(1'b1, CF, 8'h03, q);
		access(emb_pkg::EMB_READ, 1'b0, 16'h0050, 8'h00);
		expect_t(NA, 16'd2048, NA, NA);
		@(posedge sys_clk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		wb(1'b0, CK, 8'h00, q);
		chk_reg("stretch after reset", q, 8'h01);
		$display("test slow done");
	endtask
	// watchdog cuts a hang short
	initial
	begin
		repeat (30000) @(posedge sys_clk_in);
		n_fail++;
		$display("[FAIL] %0t watchdog expired", $time);
		end_of_test();
	end
	// main sequence
	initial
	begin
		repeat (2) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		t_regs();
		t_fetch();
		t_stretch();
		t_page();
		t_slow();
		end_of_test();
	end
endmodule
`default_nettype wire
